// ---- hdl/cis_pkg.sv ----
/*
  Constants for the comparator 0 input-selection register bank.
  Assumes a core-side special-function-register port with page and address.
*/
`default_nettype none

package cis_pkg;

  localparam logic [7:0] CIS_SFR_PAGE    = 8'h00;
  localparam logic [7:0] CIS_SFR_ADDR    = 8'h9f;
  localparam logic [7:0] CIS_RESET_VALUE = 8'hff;
  localparam logic [7:0] CIS_RDATA_IDLE  = 8'h00;

  // Select outputs after reset follow the all-ones register value.
  localparam logic [8:0] CIS_NEG_SEL_RESET = 9'h100;
  localparam logic [9:0] CIS_POS_SEL_RESET = 10'h200;

  localparam int CIS_NEG_MSB = 7;
  localparam int CIS_NEG_LSB = 4;
  localparam int CIS_POS_MSB = 3;
  localparam int CIS_POS_LSB = 0;

  // Source one-hot widths and positions.
  localparam int CIS_NEG_SRC_W = 9;
  localparam int CIS_POS_SRC_W = 10;

  localparam logic [3:0] CIS_CODE_PIN0  = 4'h0;
  localparam logic [3:0] CIS_CODE_PIN1  = 4'h1;
  localparam logic [3:0] CIS_CODE_PIN2  = 4'h2;
  localparam logic [3:0] CIS_CODE_PIN3  = 4'h3;
  localparam logic [3:0] CIS_CODE_P1_A  = 4'h6;
  localparam logic [3:0] CIS_CODE_P1_B  = 4'h7;
  localparam logic [3:0] CIS_CODE_TOUCH = 4'hc;
  localparam logic [3:0] CIS_CODE_HALF  = 4'hd;
  localparam logic [3:0] CIS_CODE_SUP_A = 4'he;
  localparam logic [3:0] CIS_CODE_SUP_B = 4'hf;

endpackage

`default_nettype wire

// ---- hdl/cis_comparator0_input_select.sv ----
/*
  Comparator 0 input-selection register and its decoded mux selects.
  Assumes the core presents one-cycle SFR read/write strobes with page
  and address; reads return data on the cycle after the strobe.
  Assumes the analog switches outside this block close on a one-hot
  select and open on an all-zero select, and that the page and address
  are stable while a strobe is high.
*/
`default_nettype none

module cis_comparator0_input_select (
  input  wire logic       ref_clk,     // Core clock, 250 MHz.
  input  wire logic       sys_rst,     // Asynchronous reset, active high.
  input  wire logic [7:0] sfr_page,    // Current SFR page.
  input  wire logic [7:0] sfr_addr,    // SFR address.
  input  wire logic       sfr_wr,      // Write strobe, one cycle.
  input  wire logic       sfr_rd,      // Read strobe, one cycle.
  input  wire logic [7:0] sfr_wdata,   // Write data.
  output logic      [7:0] sfr_rdata,   // Read data, valid after sfr_rd.
  output logic            sfr_rvalid,  // Read data valid pulse.
  output logic      [8:0] neg_sel,     // One-hot negative source select.
  output logic      [9:0] pos_sel      // One-hot positive source select.
);

  // Stored selection word.
  logic [7:0] comparator0_input_select_reg_q;
  logic [7:0] comparator0_input_select_reg_d;

  // Read port state.
  logic [7:0] sfr_rdata_q;
  logic [7:0] sfr_rdata_d;
  logic       sfr_rvalid_q;
  logic       sfr_rvalid_d;

  // Registered switch selects.
  logic [8:0] neg_sel_q;
  logic [8:0] neg_sel_d;
  logic [9:0] pos_sel_q;
  logic [9:0] pos_sel_d;

  // Decode helpers.
  logic       hit;
  logic [3:0] negative_input_selector;
  logic [3:0] positive_input_selector;

  // Address decode shared by the write and the read path.
  always_comb begin
    hit = (sfr_page == cis_pkg::CIS_SFR_PAGE) &&
          (sfr_addr == cis_pkg::CIS_SFR_ADDR);
  end

  // A hitting write replaces all eight bits at once.
  always_comb begin
    comparator0_input_select_reg_d = comparator0_input_select_reg_q;
    if (hit && sfr_wr) begin
      comparator0_input_select_reg_d = sfr_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      comparator0_input_select_reg_q <= cis_pkg::CIS_RESET_VALUE;
    end else begin
      comparator0_input_select_reg_q <= comparator0_input_select_reg_d;
    end
  end

  // The read samples the stored word before any write of the same cycle,
  // so a read beside a write returns the old selection, never a mix.
  always_comb begin
    sfr_rvalid_d = hit && sfr_rd;
    sfr_rdata_d  = sfr_rdata_q;
    if (hit && sfr_rd) begin
      sfr_rdata_d = comparator0_input_select_reg_q;
    end else if (sfr_rd) begin
      sfr_rdata_d = cis_pkg::CIS_RDATA_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata_q  <= cis_pkg::CIS_RDATA_IDLE;
      sfr_rvalid_q <= 1'b0;
    end else begin
      sfr_rdata_q  <= sfr_rdata_d;
      sfr_rvalid_q <= sfr_rvalid_d;
    end
  end

  // Selects follow the new register value so they change with the write.
  // Only one switch of each multiplexer may close at a time: two closed
  // switches would short two sources together, so the selects are one-hot.
  // Reserved codes leave every switch of that multiplexer open; the stored
  // code still reads back unchanged.
  always_comb begin
    negative_input_selector = comparator0_input_select_reg_d[
      cis_pkg::CIS_NEG_MSB:cis_pkg::CIS_NEG_LSB];
    positive_input_selector = comparator0_input_select_reg_d[
      cis_pkg::CIS_POS_MSB:cis_pkg::CIS_POS_LSB];
    neg_sel_d = 9'h000;
    pos_sel_d = 10'h000;
    case (negative_input_selector)
      cis_pkg::CIS_CODE_PIN0: begin
        neg_sel_d = 9'h001; // Port 0 pin 1.
      end
      cis_pkg::CIS_CODE_PIN1: begin
        neg_sel_d = 9'h002; // Port 0 pin 3.
      end
      cis_pkg::CIS_CODE_PIN2: begin
        neg_sel_d = 9'h004; // Port 0 pin 5.
      end
      cis_pkg::CIS_CODE_PIN3: begin
        neg_sel_d = 9'h008; // Port 0 pin 7.
      end
      cis_pkg::CIS_CODE_P1_A: begin
        neg_sel_d = 9'h010; // Port 1 pin 5.
      end
      cis_pkg::CIS_CODE_TOUCH: begin
        neg_sel_d = 9'h020; // Touch-sense reference.
      end
      cis_pkg::CIS_CODE_HALF: begin
        neg_sel_d = 9'h040; // Half supply.
      end
      cis_pkg::CIS_CODE_SUP_A: begin
        neg_sel_d = 9'h080; // Digital supply.
      end
      cis_pkg::CIS_CODE_SUP_B: begin
        neg_sel_d = 9'h100; // Ground.
      end
      default: begin
        neg_sel_d = 9'h000;
      end
    endcase
    case (positive_input_selector)
      cis_pkg::CIS_CODE_PIN0: begin
        pos_sel_d = 10'h001; // Port 0 pin 0.
      end
      cis_pkg::CIS_CODE_PIN1: begin
        pos_sel_d = 10'h002; // Port 0 pin 2.
      end
      cis_pkg::CIS_CODE_PIN2: begin
        pos_sel_d = 10'h004; // Port 0 pin 4.
      end
      cis_pkg::CIS_CODE_PIN3: begin
        pos_sel_d = 10'h008; // Port 0 pin 6.
      end
      cis_pkg::CIS_CODE_P1_A: begin
        pos_sel_d = 10'h010; // Port 1 pin 4.
      end
      cis_pkg::CIS_CODE_P1_B: begin
        pos_sel_d = 10'h020; // Port 1 pin 6.
      end
      cis_pkg::CIS_CODE_TOUCH: begin
        pos_sel_d = 10'h040; // Touch-sense reference.
      end
      cis_pkg::CIS_CODE_HALF: begin
        pos_sel_d = 10'h080; // Half supply.
      end
      cis_pkg::CIS_CODE_SUP_A: begin
        pos_sel_d = 10'h100; // Battery supply.
      end
      cis_pkg::CIS_CODE_SUP_B: begin
        pos_sel_d = 10'h200; // Main supply.
      end
      default: begin
        pos_sel_d = 10'h000;
      end
    endcase
  end

  // The reset selects match the decode of the all-ones reset word.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      neg_sel_q <= cis_pkg::CIS_NEG_SEL_RESET;
      pos_sel_q <= cis_pkg::CIS_POS_SEL_RESET;
    end else begin
      neg_sel_q <= neg_sel_d;
      pos_sel_q <= pos_sel_d;
    end
  end

  assign sfr_rdata  = sfr_rdata_q;
  assign sfr_rvalid = sfr_rvalid_q;
  assign neg_sel    = neg_sel_q;
  assign pos_sel    = pos_sel_q;

endmodule

`default_nettype wire

// ---- verification/cis_chk.sv ----
/* Checker for the comparator 0 selection register.
   Bound to the register block; sees its ports only. */
`default_nettype none
module cis_chk (
  input wire logic       ref_clk,    // Clock.
  input wire logic       sys_rst,    // Reset, active high.
  input wire logic       sfr_wr,     // Write strobe.
  input wire logic       sfr_rd,     // Read strobe.
  input wire logic [7:0] sfr_page,   // Page.
  input wire logic [7:0] sfr_addr,   // Address.
  input wire logic [7:0] sfr_wdata,  // Write data.
  input wire logic       sfr_rvalid, // Read valid.
  input wire logic [7:0] sfr_rdata,  // Read data.
  input wire logic [8:0] neg_sel,    // Negative select.
  input wire logic [9:0] pos_sel     // Positive select.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire hit = sfr_page == 8'h00 && sfr_addr == 8'h9f;
  function automatic logic [9:0] dec(logic [3:0] c, logic p);
    return c < 4'h4 ? 10'h1 << c : c == 4'h6 ? 10'h010 : p && c == 4'h7 ?
      10'h020 : c > 4'hb ? 10'h1 << (c - 4'h7 + p) : 10'h0;
  endfunction
  a_read_valid: assert property (sfr_rd && hit |=> sfr_rvalid)
    else $error("hit read gave no valid");
  a_miss_quiet: assert property (sfr_rd && !hit |=>
    !sfr_rvalid && sfr_rdata == 8'h00) else $error("miss read answered");
  a_write_read_back: assert property (sfr_wr && hit && !sfr_rd ##1
    !sfr_wr ##1 sfr_rd && hit && !sfr_wr |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("read back differs");
  a_neg_decode: assert property (sfr_wr && hit |=>
    {1'b0, neg_sel} == dec($past(sfr_wdata[7:4]), 1'b0)) else $error("neg");
  a_pos_decode: assert property (sfr_wr && hit |=>
    pos_sel == dec($past(sfr_wdata[3:0]), 1'b1)) else $error("pos");
  c_write_hit: cover property (sfr_wr && hit);
  c_read_hit: cover property (sfr_rd && hit ##1 sfr_rvalid);
  c_read_miss: cover property (sfr_rd && !hit);
endmodule
bind cis_comparator0_input_select cis_chk chk_u (.ref_clk, .sys_rst, .sfr_wr,
  .sfr_rd, .sfr_page, .sfr_addr, .sfr_wdata, .sfr_rvalid, .sfr_rdata,
  .neg_sel, .pos_sel);
`default_nettype wire

// ---- verification/cis_comparator0_input_select_bench.sv ----
/* Bench for the comparator 0 selection register.
   Assumes the checker is bound in from its own file. */
`default_nettype none
module cis_comparator0_input_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rvalid;
  logic [7:0] sfr_page = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [8:0] neg_sel;
  logic [9:0] pos_sel;
  int n_errors = 0, tests_run = 0, cyc = 0;
  int ni[16] = '{0, 1, 2, 3, -1, -1, 4, -1, -1, -1, -1, -1, 5, 6, 7, 8};
  int pi[16] = '{0, 1, 2, 3, -1, -1, 4, 5, -1, -1, -1, -1, 6, 7, 8, 9};
  cis_comparator0_input_select dut_u (.ref_clk, .sys_rst, .sfr_page, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_rvalid, .neg_sel, .pos_sel);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input string nm, input logic [9:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task acc(input logic [1:0] wr, input logic [15:0] pa, input logic [7:0] d);
    @(posedge ref_clk);
    {sfr_wr, sfr_rd} <= wr;
    {sfr_page, sfr_addr} <= pa;
    sfr_wdata <= d;
    @(posedge ref_clk);
    {sfr_wr, sfr_rd} <= 2'b00;
    #1;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task t_reset;
    acc(2'b01, 16'h009f, 8'h00);
    chk("rdata", sfr_rdata, 10'h0ff);
    chk("neg", neg_sel, 10'h100);
    chk("pos", pos_sel, 10'h200);
  endtask
  task t_codes;
    for (int c = 0; c < 16; c++) begin
      acc(2'b10, 16'h009f, {c[3:0], 4'hf - c[3:0]});
      chk("neg", neg_sel, ni[c] < 0 ? 10'h0 : 10'h1 << ni[c]);
      chk("pos", pos_sel, pi[15-c] < 0 ? 10'h0 : 10'h1 << pi[15-c]);
      acc(2'b01, 16'h009f, 8'h00);
      chk("rdata", sfr_rdata, {c[3:0], 4'hf - c[3:0]});
      chk("rvalid", sfr_rvalid, 10'h1);
    end
  endtask
  task t_miss;
    acc(2'b10, 16'h019f, 8'h00);
    acc(2'b10, 16'h009e, 8'h00);
    acc(2'b01, 16'h009e, 8'h00);
    chk("rvalid", sfr_rvalid, 10'h0);
    acc(2'b11, 16'h009f, 8'h06);
    chk("rdata", sfr_rdata, 10'h0f0);
    chk("neg", neg_sel, 10'h001);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_codes;
    t_miss;
    give_verdict;
  end
endmodule
`default_nettype wire
